/* File: inc/remap_defines.vh */
`ifndef REMAP_DEFINES_VH
`define REMAP_DEFINES_VH

// Register bus geometry.
`define ADDR_W              12
`define DATA_W              8
`define SEL_W               5

// Lock control register and its single implemented bit.
`define OFS_LOCK_CONTROL    12'hEBF
`define LOCK_BIT            0
`define LOCK_RESET          1'b0

// Input-select registers.
`define OFS_EXT_IRQ1        12'hEE1
`define OFS_EXT_IRQ2        12'hEE2
`define OFS_EXT_IRQ3        12'hEE3
`define OFS_TIMER_A_CLOCK   12'hEE4
`define OFS_TIMER_C_CLOCK   12'hEE6
`define OFS_CAPTURE1        12'hEE8
`define OFS_CAPTURE2        12'hEE9
`define OFS_CAPTURE3        12'hEEA
`define OFS_TIMER_B_GATE    12'hEF2
`define OFS_TIMER_C_GATE    12'hEF3
`define OFS_TIMER_E_GATE    12'hEF4
`define NUM_SELECTS         11
`define SEL_RESET           5'h1F

// Unlock key register and the two key bytes.
`define OFS_UNLOCK_KEY      12'hEA6
`define KEY_FIRST           8'h55
`define KEY_SECOND          8'hAA

// Read-only register showing the mapping register count of this variant.
`define OFS_MAP_INFO        12'hEA5
`define REG_COUNT_LARGE     8'h25
`define REG_COUNT_SMALL     8'h1F

// Remappable pins and which of them are bonded out per package variant.
`define PIN_COUNT           32
`define PIN_MASK_LARGE      32'h01FFFFFF
`define PIN_MASK_SMALL      32'h0007FFFF
`define INACTIVE_LEVEL      1'b0

`endif

/* File: core/pin_select_reg.v */
`timescale 1ns/1ps
`include "remap_defines.vh"

module pin_select_reg (
    // Clock and reset.
    input  wire                   ref_clk,
    input  wire                   rst,
    // Qualified write from the bus decoder.
    input  wire                   wr_en,
    input  wire [`SEL_W-1:0]      wr_sel,
    // Synchronised pins and the implemented-pin mask.
    input  wire [`PIN_COUNT-1:0]  pins,
    input  wire [`PIN_COUNT-1:0]  impl_mask,
    // Stored select, routed peripheral input and integrity flag.
    output reg  [`SEL_W-1:0]      sel_q,
    output reg                    periph_q,
    output wire                   mismatch
);

    reg [`SEL_W-1:0] shadow_q;

    // Select field and its shadow copy load together on a qualified write.
    always @(posedge ref_clk) begin
        if (rst) begin
            sel_q    <= `SEL_RESET;
            shadow_q <= `SEL_RESET;
        end else if (wr_en) begin
            sel_q    <= wr_sel;
            shadow_q <= wr_sel;
        end
    end

    // Route the chosen pin; a missing pin gives the inactive level.
    always @(posedge ref_clk) begin
        if (rst) begin
            periph_q <= `INACTIVE_LEVEL;
        end else if (impl_mask[sel_q]) begin
            periph_q <= pins[sel_q];
        end else begin
            periph_q <= `INACTIVE_LEVEL;
        end
    end

    // Any divergence from the shadow copy is an unexpected change.
    assign mismatch = (sel_q != shadow_q);

endmodule

/* File: core/remap_input_select_lock.v */
`timescale 1ns/1ps
`include "remap_defines.vh"

module remap_input_select_lock #(
    parameter LARGE_PACKAGE = 1
) (
    // Clock and reset.
    input  wire                   ref_clk,
    input  wire                   rst,
    // Register port.
    input  wire [`ADDR_W-1:0]     addr,
    input  wire [`DATA_W-1:0]     wr_data,
    input  wire                   wr_stb,
    input  wire                   rd_stb,
    output reg  [`DATA_W-1:0]     rd_data_q,
    // Configuration option and remappable pins, both asynchronous.
    input  wire                   one_shot_lock_option,
    input  wire [`PIN_COUNT-1:0]  remappable_pin,
    // Routed peripheral inputs.
    output wire                   ext_irq_one,
    output wire                   ext_irq_two,
    output wire                   ext_irq_three,
    output wire                   timer_a_clock_in,
    output wire                   timer_c_clock_in,
    output wire                   capture1_in,
    output wire                   capture2_in,
    output wire                   capture3_in,
    output wire                   timer_b_gate_in,
    output wire                   timer_c_gate_in,
    output wire                   timer_e_gate_in,
    // Lock state and integrity fault.
    output reg                    map_write_lock,
    output reg                    config_mismatch_reset_q
);

    // Unlock sequence states.
    localparam [1:0] KEY_IDLE = 2'b00;
    localparam [1:0] KEY_HALF = 2'b01;
    localparam [1:0] KEY_OPEN = 2'b10;

    localparam [`PIN_COUNT-1:0] IMPL_MASK = LARGE_PACKAGE ? `PIN_MASK_LARGE : `PIN_MASK_SMALL;
    localparam [`DATA_W-1:0]    REG_COUNT = LARGE_PACKAGE ? `REG_COUNT_LARGE : `REG_COUNT_SMALL;

    reg  [1:0]                      key_q;
    reg  [1:0]                      key_d;
    reg                             lock_shadow_q;
    reg                             option_meta_q;
    reg                             option_sync_q;
    reg  [`PIN_COUNT-1:0]           pin_meta_q;
    reg  [`PIN_COUNT-1:0]           pin_sync_q;
    reg  [`DATA_W-1:0]              rd_mux;
    reg                             lock_wr_ok;
    wire [`NUM_SELECTS-1:0]         sel_hit;
    wire [`NUM_SELECTS-1:0]         sel_wr;
    wire [`NUM_SELECTS-1:0]         periph;
    wire [`NUM_SELECTS-1:0]         sel_mismatch;
    wire [`SEL_W*`NUM_SELECTS-1:0]  sel_flat;
    wire                            lock_hit;
    wire                            key_hit;
    integer                         k;

    // Printed offset of each input-select register by index.
    function [`ADDR_W-1:0] sel_offset;
        input integer idx;
        begin
            case (idx)
                0:       sel_offset = `OFS_EXT_IRQ1;
                1:       sel_offset = `OFS_EXT_IRQ2;
                2:       sel_offset = `OFS_EXT_IRQ3;
                3:       sel_offset = `OFS_TIMER_A_CLOCK;
                4:       sel_offset = `OFS_TIMER_C_CLOCK;
                5:       sel_offset = `OFS_CAPTURE1;
                6:       sel_offset = `OFS_CAPTURE2;
                7:       sel_offset = `OFS_CAPTURE3;
                8:       sel_offset = `OFS_TIMER_B_GATE;
                9:       sel_offset = `OFS_TIMER_C_GATE;
                default: sel_offset = `OFS_TIMER_E_GATE;
            endcase
        end
    endfunction

    // Two-stage synchronisers for the option strap and the pins.
    always @(posedge ref_clk) begin
        if (rst) begin
            option_meta_q <= 1'b0;
            option_sync_q <= 1'b0;
            pin_meta_q    <= {`PIN_COUNT{1'b0}};
            pin_sync_q    <= {`PIN_COUNT{1'b0}};
        end else begin
            option_meta_q <= one_shot_lock_option;
            option_sync_q <= option_meta_q;
            pin_meta_q    <= remappable_pin;
            pin_sync_q    <= pin_meta_q;
        end
    end

    assign lock_hit = (addr == `OFS_LOCK_CONTROL);
    assign key_hit  = (addr == `OFS_UNLOCK_KEY);

    // Unlock sequence: first key, second key, then one lock write.
    always @* begin
        key_d = key_q;
        if (wr_stb || rd_stb) begin
            case (key_q)
                KEY_IDLE: begin
                    if (wr_stb && key_hit && wr_data == `KEY_FIRST) begin
                        key_d = KEY_HALF;
                    end
                end
                KEY_HALF: begin
                    if (wr_stb && key_hit && wr_data == `KEY_SECOND) begin
                        key_d = KEY_OPEN;
                    end else if (wr_stb && key_hit && wr_data == `KEY_FIRST) begin
                        key_d = KEY_HALF;
                    end else begin
                        key_d = KEY_IDLE;
                    end
                end
                KEY_OPEN: begin
                    key_d = KEY_IDLE;
                end
                default: begin
                    key_d = KEY_IDLE;
                end
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            key_q <= KEY_IDLE;
        end else begin
            key_q <= key_d;
        end
    end

    // A lock write counts only as the next access after the key pair.
    always @* begin
        lock_wr_ok = wr_stb && lock_hit && (key_q == KEY_OPEN);
        if (option_sync_q && map_write_lock && !wr_data[`LOCK_BIT]) begin
            lock_wr_ok = 1'b0;
        end
    end

    // Lock bit and its shadow; only bit 0 is stored.
    always @(posedge ref_clk) begin
        if (rst) begin
            map_write_lock <= `LOCK_RESET;
            lock_shadow_q  <= `LOCK_RESET;
        end else if (lock_wr_ok) begin
            map_write_lock <= wr_data[`LOCK_BIT];
            lock_shadow_q  <= wr_data[`LOCK_BIT];
        end
    end

    // Address match and lock-qualified write per select; locked writes drop without any error signal.
    genvar g;
    generate
        for (g = 0; g < `NUM_SELECTS; g = g + 1) begin : sel_dec
            assign sel_hit[g] = (addr == sel_offset(g));
            assign sel_wr[g]  = wr_stb && sel_hit[g] && !map_write_lock;
        end
    endgenerate

    // Select registers for the three external interrupts.
    pin_select_reg u_irq1_sel (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (sel_wr[0]),
        .wr_sel    (wr_data[`SEL_W-1:0]),
        .pins      (pin_sync_q),
        .impl_mask (IMPL_MASK),
        .sel_q     (sel_flat[`SEL_W*0 +: `SEL_W]),
        .periph_q  (periph[0]),
        .mismatch  (sel_mismatch[0])
    );
    pin_select_reg u_irq2_sel (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (sel_wr[1]),
        .wr_sel    (wr_data[`SEL_W-1:0]),
        .pins      (pin_sync_q),
        .impl_mask (IMPL_MASK),
        .sel_q     (sel_flat[`SEL_W*1 +: `SEL_W]),
        .periph_q  (periph[1]),
        .mismatch  (sel_mismatch[1])
    );
    pin_select_reg u_irq3_sel (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (sel_wr[2]),
        .wr_sel    (wr_data[`SEL_W-1:0]),
        .pins      (pin_sync_q),
        .impl_mask (IMPL_MASK),
        .sel_q     (sel_flat[`SEL_W*2 +: `SEL_W]),
        .periph_q  (periph[2]),
        .mismatch  (sel_mismatch[2])
    );

    // Select registers for the two timer clock inputs.
    pin_select_reg u_tmra_clk_sel (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (sel_wr[3]),
        .wr_sel    (wr_data[`SEL_W-1:0]),
        .pins      (pin_sync_q),
        .impl_mask (IMPL_MASK),
        .sel_q     (sel_flat[`SEL_W*3 +: `SEL_W]),
        .periph_q  (periph[3]),
        .mismatch  (sel_mismatch[3])
    );
    pin_select_reg u_tmrc_clk_sel (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (sel_wr[4]),
        .wr_sel    (wr_data[`SEL_W-1:0]),
        .pins      (pin_sync_q),
        .impl_mask (IMPL_MASK),
        .sel_q     (sel_flat[`SEL_W*4 +: `SEL_W]),
        .periph_q  (periph[4]),
        .mismatch  (sel_mismatch[4])
    );

    // Select registers for the three capture inputs.
    pin_select_reg u_cap1_sel (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (sel_wr[5]),
        .wr_sel    (wr_data[`SEL_W-1:0]),
        .pins      (pin_sync_q),
        .impl_mask (IMPL_MASK),
        .sel_q     (sel_flat[`SEL_W*5 +: `SEL_W]),
        .periph_q  (periph[5]),
        .mismatch  (sel_mismatch[5])
    );
    pin_select_reg u_cap2_sel (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (sel_wr[6]),
        .wr_sel    (wr_data[`SEL_W-1:0]),
        .pins      (pin_sync_q),
        .impl_mask (IMPL_MASK),
        .sel_q     (sel_flat[`SEL_W*6 +: `SEL_W]),
        .periph_q  (periph[6]),
        .mismatch  (sel_mismatch[6])
    );
    pin_select_reg u_cap3_sel (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (sel_wr[7]),
        .wr_sel    (wr_data[`SEL_W-1:0]),
        .pins      (pin_sync_q),
        .impl_mask (IMPL_MASK),
        .sel_q     (sel_flat[`SEL_W*7 +: `SEL_W]),
        .periph_q  (periph[7]),
        .mismatch  (sel_mismatch[7])
    );

    // Select registers for the three timer gate inputs.
    pin_select_reg u_tmrb_gate_sel (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (sel_wr[8]),
        .wr_sel    (wr_data[`SEL_W-1:0]),
        .pins      (pin_sync_q),
        .impl_mask (IMPL_MASK),
        .sel_q     (sel_flat[`SEL_W*8 +: `SEL_W]),
        .periph_q  (periph[8]),
        .mismatch  (sel_mismatch[8])
    );
    pin_select_reg u_tmrc_gate_sel (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (sel_wr[9]),
        .wr_sel    (wr_data[`SEL_W-1:0]),
        .pins      (pin_sync_q),
        .impl_mask (IMPL_MASK),
        .sel_q     (sel_flat[`SEL_W*9 +: `SEL_W]),
        .periph_q  (periph[9]),
        .mismatch  (sel_mismatch[9])
    );
    pin_select_reg u_tmre_gate_sel (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (sel_wr[10]),
        .wr_sel    (wr_data[`SEL_W-1:0]),
        .pins      (pin_sync_q),
        .impl_mask (IMPL_MASK),
        .sel_q     (sel_flat[`SEL_W*10 +: `SEL_W]),
        .periph_q  (periph[10]),
        .mismatch  (sel_mismatch[10])
    );

    // Peripheral inputs, each from its select register's output flop.
    assign ext_irq_one      = periph[0];
    assign ext_irq_two      = periph[1];
    assign ext_irq_three    = periph[2];
    assign timer_a_clock_in = periph[3];
    assign timer_c_clock_in = periph[4];
    assign capture1_in      = periph[5];
    assign capture2_in      = periph[6];
    assign capture3_in      = periph[7];
    assign timer_b_gate_in  = periph[8];
    assign timer_c_gate_in  = periph[9];
    assign timer_e_gate_in  = periph[10];

    // Integrity fault latches until the device reset it requests.
    always @(posedge ref_clk) begin
        if (rst) begin
            config_mismatch_reset_q <= 1'b0;
        end else if ((|sel_mismatch) || (map_write_lock != lock_shadow_q)) begin
            config_mismatch_reset_q <= 1'b1;
        end
    end

    // Read multiplexer; unused bits and unmapped addresses read zero.
    always @* begin
        rd_mux = {`DATA_W{1'b0}};
        if (lock_hit) begin
            rd_mux = {{(`DATA_W-1){1'b0}}, map_write_lock};
        end else if (addr == `OFS_MAP_INFO) begin
            rd_mux = REG_COUNT;
        end
        for (k = 0; k < `NUM_SELECTS; k = k + 1) begin
            if (sel_hit[k]) begin
                rd_mux = {{(`DATA_W-`SEL_W){1'b0}}, sel_flat[`SEL_W*k +: `SEL_W]};
            end
        end
    end

    // Read data stand for the single cycle after the read strobe.
    always @(posedge ref_clk) begin
        if (rst) begin
            rd_data_q <= {`DATA_W{1'b0}};
        end else if (rd_stb) begin
            rd_data_q <= rd_mux;
        end else begin
            rd_data_q <= {`DATA_W{1'b0}};
        end
    end

endmodule

/* File: tb/remap_lock_assertions.sv */
`timescale 1ns/1ps
`include "remap_defines.vh"
module remap_lock_checker #(
    parameter LARGE_PACKAGE = 1
) (
    // Clock and reset.
    input wire        ref_clk,
    input wire        rst,
    // Register port.
    input wire [11:0] addr,
    input wire [7:0]  wr_data,
    input wire        wr_stb,
    input wire        rd_stb,
    input wire [7:0]  rd_data_q,
    // Lock state and option.
    input wire        one_shot_lock_option,
    input wire        map_write_lock,
    input wire        config_mismatch_reset_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // The two key writes that must directly precede a lock write.
    sequence s_key;
        wr_stb && addr == 12'hEA6 && wr_data == 8'h55 ##1 wr_stb && addr == 12'hEA6 && wr_data == 8'hAA;
    endsequence
    property p_reset; disable iff (1'b0) rst |=> !map_write_lock && rd_data_q == 8'h00; endproperty
    a_reset: assert property (p_reset) else $error("lock or read data not cleared by reset");
    property p_rd_idle; !rd_stb |=> rd_data_q == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
    property p_lock_set; s_key ##1 (wr_stb && addr == 12'hEBF && wr_data[0]) |=> map_write_lock; endproperty
    a_lock_set: assert property (p_lock_set) else $error("keyed lock write did not lock");
    property p_lock_hold; !(wr_stb && addr == 12'hEBF) |=> $stable(map_write_lock); endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock changed without a lock write");
    property p_lock_nokey; wr_stb && addr == 12'hEBF && $past(rd_stb) |=> $stable(map_write_lock); endproperty
    a_lock_nokey: assert property (p_lock_nokey) else $error("lock changed without key");
    property p_one_shot; one_shot_lock_option [*3] ##0 map_write_lock |=> map_write_lock; endproperty
    a_one_shot: assert property (p_one_shot) else $error("lock cleared under one-shot option");
    property p_lock_read; rd_stb && addr == 12'hEBF |=> rd_data_q == {7'h00, $past(map_write_lock)}; endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock register read wrong");
    property p_sel_read; rd_stb && addr[11:4] == 8'hEE |=> rd_data_q[7:5] == 3'h0; endproperty
    a_sel_read: assert property (p_sel_read) else $error("select upper bits not zero");
    property p_info;
        rd_stb && addr == 12'hEA5 |=> rd_data_q == (LARGE_PACKAGE ? 8'h25 : 8'h1F);
    endproperty
    a_info: assert property (p_info) else $error("register count read wrong");
    property p_fault; config_mismatch_reset_q |=> config_mismatch_reset_q; endproperty
    a_fault: assert property (p_fault) else $error("mismatch flag dropped before reset");
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "remap_defines.vh"
module testbench;
    // Driven inputs.
    reg         ref_clk = 1'b0;
    reg         rst = 1'b1;
    reg  [11:0] addr = 12'h000;
    reg  [7:0]  wr_data = 8'h00;
    reg         wr_stb = 1'b0;
    reg         rd_stb = 1'b0;
    reg         one_shot_lock_option = 1'b0;
    reg  [31:0] remappable_pin = 32'h0;
    // Observed outputs.
    wire [7:0]  rd_data_q;
    wire [10:0] periph;
    wire        map_write_lock;
    wire        config_mismatch_reset_q;
    // Bench state.
    integer     n_fail = 0;
    integer     checks_done = 0;
    integer     seed = 41;
    integer     cycles = 0;
    integer     i;
    reg         seen = 1'b0;
    reg  [7:0]  v;
    reg  [7:0]  exp_q[$];
    reg  [4:0]  pin_q[$];
    reg  [4:0]  pe;
    integer     pin_age = 0;
    reg  [4:0]  sel_m[0:10];
    reg  [11:0] ofs[0:10];

    remap_input_select_lock #(.LARGE_PACKAGE(1)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rd_data_q(rd_data_q), .one_shot_lock_option(one_shot_lock_option), .remappable_pin(remappable_pin),
        .ext_irq_one(periph[0]), .ext_irq_two(periph[1]), .ext_irq_three(periph[2]),
        .timer_a_clock_in(periph[3]), .timer_c_clock_in(periph[4]), .capture1_in(periph[5]),
        .capture2_in(periph[6]), .capture3_in(periph[7]), .timer_b_gate_in(periph[8]),
        .timer_c_gate_in(periph[9]), .timer_e_gate_in(periph[10]), .map_write_lock(map_write_lock),
        .config_mismatch_reset_q(config_mismatch_reset_q)
    );

    // Clock of 50 ns period.
    always #25 ref_clk = ~ref_clk;

    // Compare one read data byte against its note.
    task check_rd(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD %0t read got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Compare one single-bit level output.
    task check_bit(input got, input exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD %0t level got %b expected %b", $time, got, exp);
            end
        end
    endtask

    task final_report;
        begin
            if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask

    task wr(input [11:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            addr <= a;
            wr_data <= d;
            wr_stb <= 1'b1;
            rd_stb <= 1'b0;
        end
    endtask

    // A read notes its expected data for the monitor below.
    task rd(input [11:0] a, input [7:0] e);
        begin
            @(posedge ref_clk);
            addr <= a;
            rd_stb <= 1'b1;
            wr_stb <= 1'b0;
            exp_q.push_back(e);
        end
    endtask

    task idle;
        begin
            @(posedge ref_clk);
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
        end
    endtask

    task key(input [7:0] d);
        begin
            wr(12'hEA6, 8'h55);
            wr(12'hEA6, 8'hAA);
            wr(12'hEBF, d);
        end
    endtask

    task do_reset;
        begin
            rst <= 1'b1;
            repeat (10) @(posedge ref_clk);
            rst <= 1'b0;
        end
    endtask

    // Drive random pins and note the level one routed input must show four edges later.
    task route(input integer k);
        reg e;
        begin
            idle;
            remappable_pin <= $random(seed);
            @(negedge ref_clk);
            e = (sel_m[k] < 25) ? remappable_pin[sel_m[k]] : `INACTIVE_LEVEL;
            pin_q.push_back({k[3:0], e});
            repeat (5) @(posedge ref_clk);
        end
    endtask

    // Takes the oldest note whenever its result stands; also guards against hangs.
    always @(posedge ref_clk) begin
        if (seen) check_rd(rd_data_q, exp_q.pop_front());
        seen <= rd_stb;
        if (pin_q.size() > 0) begin
            pin_age = pin_age + 1;
            if (pin_age == 4) begin
                pe = pin_q.pop_front();
                pin_age = 0;
                check_bit(periph[pe[4:1]], pe[0]);
            end
        end
        if (!rst) check_bit(config_mismatch_reset_q, 1'b0);
        cycles = cycles + 1;
        if (cycles > 3000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end

    // Main sequence.
    initial begin
        ofs = '{12'hEE1, 12'hEE2, 12'hEE3, 12'hEE4, 12'hEE6, 12'hEE8, 12'hEE9, 12'hEEA, 12'hEF2, 12'hEF3, 12'hEF4};
        do_reset;
        for (i = 0; i < 11; i = i + 1) sel_m[i] = 5'h1F;
        for (i = 0; i < 11; i = i + 1) rd(ofs[i], 8'h1F);
        rd(12'hEBF, 8'h00);
        rd(12'hEA5, 8'h25);
        rd(12'hEE5, 8'h00);
        route(0);
        for (i = 0; i < 11; i = i + 1) begin
            v = $random(seed);
            sel_m[i] = v[4:0];
            wr(ofs[i], v);
        end
        for (i = 0; i < 11; i = i + 1) rd(ofs[i], {3'h0, sel_m[i]});
        for (i = 0; i < 11; i = i + 1) route(i);
        wr(12'hEBF, 8'hFF);
        wr(12'hEA6, 8'h55);
        rd(12'hEE1, {3'h0, sel_m[0]});
        wr(12'hEA6, 8'hAA);
        wr(12'hEBF, 8'h01);
        rd(12'hEBF, 8'h00);
        wr(12'hEA6, 8'h55);
        wr(12'hEA6, 8'hAA);
        rd(12'hEBF, 8'h00);
        wr(12'hEBF, 8'h01);
        rd(12'hEBF, 8'h00);
        key(8'hFF);
        rd(12'hEBF, 8'h01);
        for (i = 0; i < 11; i = i + 1) wr(ofs[i], ~{3'h0, sel_m[i]});
        for (i = 0; i < 11; i = i + 1) rd(ofs[i], {3'h0, sel_m[i]});
        key(8'h00);
        rd(12'hEBF, 8'h00);
        wr(ofs[0], 8'h03);
        rd(ofs[0], 8'h03);
        idle;
        one_shot_lock_option <= 1'b1;
        repeat (4) @(posedge ref_clk);
        key(8'h01);
        key(8'h00);
        rd(12'hEBF, 8'h01);
        wr(ofs[0], 8'h07);
        rd(ofs[0], 8'h03);
        idle;
        do_reset;
        rd(12'hEBF, 8'h00);
        rd(ofs[0], 8'h1F);
        idle;
        repeat (4) @(posedge ref_clk);
        final_report;
    end
endmodule

bind remap_input_select_lock remap_lock_checker #(.LARGE_PACKAGE(LARGE_PACKAGE)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data_q(rd_data_q), .one_shot_lock_option(one_shot_lock_option), .map_write_lock(map_write_lock),
    .config_mismatch_reset_q(config_mismatch_reset_q)
);
